/* sclm_pkg.sv */
// Shared constants and operation codes of the shift, count and long MAC slice
package sclm_pkg;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned HALF_W   = 16;
	localparam int unsigned ACC_W    = 64;
	localparam int unsigned AMT_W    = 8;
	localparam int unsigned IMM_W    = 5;
	localparam int unsigned CNT_W    = 6;
	localparam int unsigned SIGN_BIT = 31;
	localparam int unsigned HALF_MSB = 15;
	localparam int unsigned TOP_LSB  = 16;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [5:0]  ROT_SPAN = 6'h20;
	localparam logic [31:0] ALL_ZERO_CNT = 32'h0000_0020;

	typedef enum logic [3:0] {
		OP_SHIFT_LEFT      = 4'h0,
		OP_LOGIC_RIGHT     = 4'h1,
		OP_ARITH_RIGHT     = 4'h2,
		OP_ROTATE_RIGHT    = 4'h3,
		OP_ROTATE_CARRY    = 4'h4,
		OP_LEAD_ZERO_COUNT = 4'h5,
		OP_MUL_ACC_LONG    = 4'h6,
		OP_HALF_SELECT_MAC = 4'h7,
		OP_DUAL_HALF_MAC   = 4'h8
	} sclm_op_t;
endpackage

/* sclm_mul_if.sv */
// Operand pair and product of one signed multiplier
`timescale 1ns/1ps
interface sclm_mul_if #(
	parameter int unsigned W = 32
);
	logic signed [W-1:0]   a;
	logic signed [W-1:0]   b;
	logic signed [2*W-1:0] p;

	modport mult (input a, input b, output p);
	modport user (output a, output b, input p);
endinterface

/* sclm_smul.sv */
// Signed multiplier of parameterised width
`timescale 1ns/1ps
module sclm_smul #(
	parameter int unsigned W = 32
) (
	// Operands and product
	sclm_mul_if.mult mi
);
	// Full width two's complement product
	assign mi.p = mi.a * mi.b;
endmodule

/* sclm_lzc.sv */
// Leading zero counter of parameterised width
`timescale 1ns/1ps
module sclm_lzc #(
	parameter int unsigned W  = 32,
	parameter int unsigned CW = 6
) (
	// Operand and count
	input  wire logic [W-1:0]  val_i,
	output logic      [CW-1:0] cnt_o
);
	// Scan from the top; stop at first set bit
	always_comb begin
		logic found;
		found = 1'b0;
		cnt_o = CW'(W);
		for (int i = W - 1; i >= 0; i--) begin
			if (!found && val_i[i]) begin
				found = 1'b1;
				cnt_o = CW'(W - 1 - i);
			end
		end
	end
endmodule

/* sclm_datapath.sv */
// Shift flag, leading zero count and signed long MAC datapath slice
//
// How it works
// - Flag-setting shifts set N, Z from result
// - Carry gets last bit out; length zero keeps
// - Register rotate amount uses bottom byte only
// - Count zeros above highest set bit
// - Leading zero count never touches flags
// - Word MAC: signed 32x32 plus 64-bit accumulator
// - Low word is bits 31:0, high 63:32
// - Select bits pick bottom or top halfword
// - Halfword product sign-extended to 64 then added
// - Unselected halfwords play no part at all
// - Dual MAC pairs top-top and bottom-bottom
// - Crossed dual pairs top-bottom and bottom-top
// - Dual adds both products into accumulator
`timescale 1ns/1ps
module sclm_datapath (
	// Clock and reset
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_i,
	// Request from the decoder
	input  wire logic                         req_valid_i,
	input  wire sclm_pkg::sclm_op_t           op_i,
	input  wire logic                         cond_pass_i,
	input  wire logic                         flag_upd_i,
	input  wire logic                         cross_i,
	input  wire logic                         sel_first_top_i,
	input  wire logic                         sel_second_top_i,
	input  wire logic                         amt_from_reg_i,
	input  wire logic [sclm_pkg::IMM_W-1:0]   amt_imm_i,
	// Operands from the register file
	input  wire logic [sclm_pkg::DATA_W-1:0]  first_operand_reg_i,
	input  wire logic [sclm_pkg::DATA_W-1:0]  second_operand_reg_i,
	input  wire logic [sclm_pkg::DATA_W-1:0]  accum_low_word_i,
	input  wire logic [sclm_pkg::DATA_W-1:0]  accum_high_word_i,
	input  wire logic                         flag_c_i,
	// Results back to the register file
	output logic                              done_o,
	output logic                              wr_result_o,
	output logic                              wr_accum_o,
	output logic [sclm_pkg::DATA_W-1:0]       result_o,
	output logic [sclm_pkg::DATA_W-1:0]       accum_low_word_o,
	output logic [sclm_pkg::DATA_W-1:0]       accum_high_word_o,
	output logic                              flags_wr_o,
	output logic                              flag_n_o,
	output logic                              flag_z_o,
	output logic                              flag_c_o
);
	import sclm_pkg::*;

	logic [AMT_W-1:0]      shift_amt;
	logic [IMM_W-1:0]      rot_dist;
	logic [DATA_W-1:0]     sh_res;
	logic                  sh_carry;
	logic                  is_shift;
	logic [DATA_W:0]       wide_left;
	logic [DATA_W:0]       wide_right;
	logic [DATA_W:0]       wide_arith;
	logic [CNT_W-1:0]      lz_cnt;
	logic [ACC_W-1:0]      acc_in;
	logic [ACC_W-1:0]      mac_sum;
	logic [HALF_W-1:0]     first_bot;
	logic [HALF_W-1:0]     first_top;
	logic [HALF_W-1:0]     second_bot;
	logic [HALF_W-1:0]     second_top;
	logic [ACC_W-1:0]      ext_p0;
	logic [ACC_W-1:0]      ext_p1;
	logic                  is_mac;

	// Multipliers: one full word, two halfword lanes
	sclm_mul_if #(.W(DATA_W)) mw_if ();
	sclm_mul_if #(.W(HALF_W)) h0_if ();
	sclm_mul_if #(.W(HALF_W)) h1_if ();

	sclm_smul #(.W(DATA_W)) u_mul_word (
		.mi (mw_if)
	);
	sclm_smul #(.W(HALF_W)) u_mul_h0 (
		.mi (h0_if)
	);
	sclm_smul #(.W(HALF_W)) u_mul_h1 (
		.mi (h1_if)
	);

	// Leading zero counter on the second operand
	sclm_lzc #(.W(DATA_W), .CW(CNT_W)) u_lzc (
		.val_i (second_operand_reg_i),
		.cnt_o (lz_cnt)
	);

	// Shift distance: bottom byte of register or immediate
	assign shift_amt = amt_from_reg_i ? second_operand_reg_i[AMT_W-1:0]
		: {3'h0, amt_imm_i};
	assign rot_dist  = shift_amt[IMM_W-1:0];
	assign is_shift  = (op_i == OP_SHIFT_LEFT) || (op_i == OP_LOGIC_RIGHT)
		|| (op_i == OP_ARITH_RIGHT) || (op_i == OP_ROTATE_RIGHT)
		|| (op_i == OP_ROTATE_CARRY);
	assign is_mac    = (op_i == OP_MUL_ACC_LONG)
		|| (op_i == OP_HALF_SELECT_MAC) || (op_i == OP_DUAL_HALF_MAC);

	// Extended shifts keep the last bit out in the spare position
	assign wide_left  = {1'b0, first_operand_reg_i} << shift_amt;
	assign wide_right = {first_operand_reg_i, 1'b0} >> shift_amt;
	assign wide_arith = $unsigned($signed({first_operand_reg_i, 1'b0})
		>>> shift_amt); // Self-determined so the sign fill survives

	// Shift result and carry out
	always_comb begin
		sh_res   = first_operand_reg_i;
		sh_carry = flag_c_i;
		case (op_i)
			OP_SHIFT_LEFT: begin
				if (shift_amt != 8'h00) begin
					sh_res   = wide_left[DATA_W-1:0];
					sh_carry = wide_left[DATA_W];
				end
			end
			OP_LOGIC_RIGHT: begin
				if (shift_amt != 8'h00) begin
					sh_res   = wide_right[DATA_W:1];
					sh_carry = wide_right[0];
				end
			end
			OP_ARITH_RIGHT: begin
				if (shift_amt != 8'h00) begin
					sh_res   = wide_arith[DATA_W:1];
					sh_carry = wide_arith[0];
				end
			end
			OP_ROTATE_RIGHT: begin
				if (shift_amt != 8'h00) begin
					sh_res   = (first_operand_reg_i >> rot_dist)
						| (first_operand_reg_i << (ROT_SPAN - {1'b0, rot_dist}));
					sh_carry = sh_res[SIGN_BIT];
				end
			end
			OP_ROTATE_CARRY: begin
				sh_res   = {flag_c_i, first_operand_reg_i[DATA_W-1:1]};
				sh_carry = first_operand_reg_i[0];
			end
			default: begin
				sh_res   = first_operand_reg_i;
				sh_carry = flag_c_i;
			end
		endcase
	end

	// Halfword fields of both operands
	assign first_bot  = first_operand_reg_i[HALF_MSB:0];
	assign first_top  = first_operand_reg_i[DATA_W-1:TOP_LSB];
	assign second_bot = second_operand_reg_i[HALF_MSB:0];
	assign second_top = second_operand_reg_i[DATA_W-1:TOP_LSB];

	// Word multiplier operands, signed
	assign mw_if.a = first_operand_reg_i;
	assign mw_if.b = second_operand_reg_i;

	// Halfword lane operands: selected, straight or crossed
	always_comb begin
		h0_if.a = first_top;
		h0_if.b = second_top;
		h1_if.a = first_bot;
		h1_if.b = second_bot;
		if (op_i == OP_HALF_SELECT_MAC) begin
			h0_if.a = sel_first_top_i ? first_top : first_bot;
			h0_if.b = sel_second_top_i ? second_top : second_bot;
		end else if (cross_i) begin
			h0_if.b = second_bot;
			h1_if.b = second_top;
		end
	end

	// Accumulator pair and sign extended lane products
	assign acc_in = {accum_high_word_i, accum_low_word_i};
	assign ext_p0 = {{(ACC_W-2*HALF_W){h0_if.p[2*HALF_W-1]}}, h0_if.p};
	assign ext_p1 = {{(ACC_W-2*HALF_W){h1_if.p[2*HALF_W-1]}}, h1_if.p};

	// Accumulation wraps at 64 bits
	always_comb begin
		case (op_i)
			OP_MUL_ACC_LONG:    mac_sum = acc_in + mw_if.p;
			OP_HALF_SELECT_MAC: mac_sum = acc_in + ext_p0;
			OP_DUAL_HALF_MAC:   mac_sum = acc_in + ext_p0 + ext_p1;
			default:            mac_sum = acc_in;
		endcase
	end

	// Completion strobe
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= req_valid_i;
		end
	end

	// Write enables, gated by the condition
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_result_o <= 1'b0;
			wr_accum_o  <= 1'b0;
			flags_wr_o  <= 1'b0;
		end else begin
			wr_result_o <= req_valid_i && cond_pass_i
				&& (is_shift || op_i == OP_LEAD_ZERO_COUNT);
			wr_accum_o  <= req_valid_i && cond_pass_i && is_mac;
			flags_wr_o  <= req_valid_i && cond_pass_i && is_shift
				&& flag_upd_i;
		end
	end

	// Result word
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_o <= WORD_RST;
		end else if (req_valid_i && cond_pass_i) begin
			if (op_i == OP_LEAD_ZERO_COUNT) begin
				result_o <= {26'h0, lz_cnt};
			end else if (is_shift) begin
				result_o <= sh_res;
			end
		end
	end

	// Accumulator write back, low and high words
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			accum_low_word_o  <= WORD_RST;
			accum_high_word_o <= WORD_RST;
		end else if (req_valid_i && cond_pass_i && is_mac) begin
			accum_low_word_o  <= mac_sum[DATA_W-1:0];
			accum_high_word_o <= mac_sum[ACC_W-1:DATA_W];
		end
	end

	// Flags from the shift result
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_n_o <= 1'b0;
			flag_z_o <= 1'b0;
			flag_c_o <= 1'b0;
		end else if (req_valid_i && cond_pass_i && is_shift && flag_upd_i) begin
			flag_n_o <= sh_res[SIGN_BIT];
			flag_z_o <= (sh_res == WORD_RST);
			flag_c_o <= sh_carry;
		end
	end

	// Reference sums for the checks
	logic signed [ACC_W-1:0] ref_a;
	logic signed [ACC_W-1:0] ref_b;
	logic [ACC_W-1:0]        ref_word;
	logic [DATA_W-1:0]       ref_rot;
	logic signed [ACC_W-1:0] ref_dual;
	assign ref_a    = $signed(first_operand_reg_i);
	assign ref_b    = $signed(second_operand_reg_i);
	assign ref_word = acc_in + ref_a * ref_b;
	assign ref_rot  = (first_operand_reg_i >> second_operand_reg_i[4:0])
		| (first_operand_reg_i << (ROT_SPAN - {1'b0,
		second_operand_reg_i[4:0]}));
	assign ref_dual = $signed(first_top)
		* $signed(cross_i ? second_bot : second_top)
		+ $signed(first_bot) * $signed(cross_i ? second_top : second_bot);

	// Checks
	a_shift_nz_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && is_shift && flag_upd_i |=> flags_wr_o
		&& flag_n_o == result_o[SIGN_BIT]
		&& flag_z_o == (result_o == WORD_RST))
		else $error("shift N or Z flag wrong");
	a_carry_zero_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && is_shift && flag_upd_i
		&& op_i != OP_ROTATE_CARRY && shift_amt == 8'h00
		|=> flag_c_o == $past(flag_c_i))
		else $error("carry changed on zero length shift");
	a_rotate_low_byte: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && op_i == OP_ROTATE_RIGHT && amt_from_reg_i
		&& second_operand_reg_i[7:0] != 8'h00 |=> result_o == $past(ref_rot))
		else $error("rotate distance not from bottom byte");
	a_lzc_all_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && op_i == OP_LEAD_ZERO_COUNT
		&& second_operand_reg_i == WORD_RST
		|=> wr_result_o && result_o == ALL_ZERO_CNT)
		else $error("zero operand count not 32");
	a_lzc_top_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && op_i == OP_LEAD_ZERO_COUNT
		&& second_operand_reg_i[SIGN_BIT] |=> result_o == WORD_RST)
		else $error("top bit set count not zero");
	a_lzc_no_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && op_i == OP_LEAD_ZERO_COUNT
		|=> !flags_wr_o && $stable(flag_c_o))
		else $error("count changed flags");
	a_word_mac_sum: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && op_i == OP_MUL_ACC_LONG
		|=> wr_accum_o && {accum_high_word_o, accum_low_word_o}
		== $past(ref_word))
		else $error("word MAC sum wrong");
	a_half_ignore: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && op_i == OP_HALF_SELECT_MAC
		&& !sel_first_top_i && !sel_second_top_i
		|=> {accum_high_word_o, accum_low_word_o} == $past(acc_in)
		+ {{32{$past(h0_if.p[31])}}, $past(h0_if.p)})
		else $error("halfword MAC sum wrong");
	a_dual_pairs: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && cond_pass_i && op_i == OP_DUAL_HALF_MAC
		|=> {accum_high_word_o, accum_low_word_o}
		== $past(acc_in) + $past(ref_dual))
		else $error("dual halfword MAC sum wrong");
	a_mac_no_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && is_mac |=> !flags_wr_o ##1 $stable(flag_z_o)
		|| flags_wr_o)
		else $error("MAC touched flags");
	a_cond_false: assert property (@(posedge core_clk_i) disable iff (rst_i)
		req_valid_i && !cond_pass_i |=> done_o && !wr_result_o && !wr_accum_o
		&& !flags_wr_o && $stable(result_o))
		else $error("failed condition still wrote");
endmodule

/* sclm_rf_model.sv */
// Register file and carry flag model facing the datapath
`timescale 1ns/1ps
module sclm_rf_model (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Preload from the bench
	input  wire logic        ld_i,
	input  wire logic [31:0] ld_lo_i,
	input  wire logic [31:0] ld_hi_i,
	input  wire logic        ld_c_i,
	// Write back from the datapath
	input  wire logic        wr_acc_i,
	input  wire logic [31:0] acc_lo_i,
	input  wire logic [31:0] acc_hi_i,
	input  wire logic        flags_wr_i,
	input  wire logic        carry_i,
	// Operands to the datapath
	output logic      [31:0] lo_o,
	output logic      [31:0] hi_o,
	output logic             c_o
);
	// Only the accumulator pair and carry flag held, never stack or program counter
	// Accumulator pair, low word in bits 31:0 of the sum
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lo_o <= 32'h0000_0000;
			hi_o <= 32'h0000_0000;
		end else if (ld_i) begin
			lo_o <= ld_lo_i;
			hi_o <= ld_hi_i;
		end else if (wr_acc_i) begin
			lo_o <= acc_lo_i;
			hi_o <= acc_hi_i;
		end
	end
	// Carry flag, written back only on flag updates
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			c_o <= 1'b0;
		end else if (ld_i) begin
			c_o <= ld_c_i;
		end else if (flags_wr_i) begin
			c_o <= carry_i;
		end
	end
endmodule

/* sclm_datapath_tb.sv */
// Self-checking bench of the shift, count and long MAC datapath
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sclm_datapath_tb;
	import sclm_pkg::*;
	logic        core_clk_i, rst_i, req_valid_i, cond_pass_i, flag_upd_i;
	logic        cross_i, sel_first_top_i, sel_second_top_i, amt_from_reg_i;
	logic [4:0]  amt_imm_i;
	sclm_op_t    op_i;
	logic [31:0] first_operand_reg_i, second_operand_reg_i;
	logic [31:0] accum_low_word_i, accum_high_word_i;
	logic [31:0] result_o, accum_low_word_o, accum_high_word_o;
	logic [31:0] ld_lo, ld_hi;
	logic        flag_c_i, done_o, wr_result_o, wr_accum_o, flags_wr_o;
	logic        flag_n_o, flag_z_o, flag_c_o, ld, ld_c;
	int          fail_count, samples_checked, cyc;
	longint      tab[4] = '{-14, -10, 21, 15};

	sclm_datapath sclm_datapath_inst (.core_clk_i, .rst_i, .req_valid_i,
		.op_i, .cond_pass_i, .flag_upd_i, .cross_i, .sel_first_top_i,
		.sel_second_top_i, .amt_from_reg_i, .amt_imm_i, .first_operand_reg_i,
		.second_operand_reg_i, .accum_low_word_i, .accum_high_word_i,
		.flag_c_i, .done_o, .wr_result_o, .wr_accum_o, .result_o,
		.accum_low_word_o, .accum_high_word_o, .flags_wr_o, .flag_n_o,
		.flag_z_o, .flag_c_o);
	sclm_rf_model sclm_rf_model_inst (.core_clk_i, .rst_i, .ld_i(ld),
		.ld_lo_i(ld_lo), .ld_hi_i(ld_hi), .ld_c_i(ld_c),
		.wr_acc_i(wr_accum_o), .acc_lo_i(accum_low_word_o),
		.acc_hi_i(accum_high_word_o), .flags_wr_i(flags_wr_o),
		.carry_i(flag_c_o), .lo_o(accum_low_word_i),
		.hi_o(accum_high_word_i), .c_o(flag_c_i));

	// Clock at 50 MHz
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	// Hang guard
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checked=%0d bad=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Preload accumulator pair and carry through the model
	task automatic load(input logic [31:0] lo, hi, input logic c);
		@(posedge core_clk_i);
		ld <= 1'b1;
		ld_lo <= lo;
		ld_hi <= hi;
		ld_c <= c;
		@(posedge core_clk_i);
		ld <= 1'b0;
	endtask
	// One request; opt = {cond, upd, cross, sel1, sel2, from_reg, imm}
	task automatic go(input sclm_op_t o, input logic [31:0] a, b,
			input logic [10:0] opt);
		@(posedge core_clk_i);
		req_valid_i <= 1'b1;
		op_i <= o;
		first_operand_reg_i <= a;
		second_operand_reg_i <= b;
		{cond_pass_i, flag_upd_i, cross_i, sel_first_top_i, sel_second_top_i,
			amt_from_reg_i, amt_imm_i} <= opt;
		@(posedge core_clk_i);
		req_valid_i <= 1'b0;
		#1;
		`CHK(done_o, 1'b1)
	endtask
	// Flag-setting shift and its expected result and carry
	task automatic sh(input sclm_op_t o, input logic [31:0] a, b,
			input logic fr, input logic [4:0] imm,
			input logic [31:0] er, input logic ec);
		go(o, a, b, {2'b11, 3'b000, fr, imm});
		`CHK(result_o, er)
		`CHK({flags_wr_o, flag_n_o, flag_z_o}, {1'b1, er[31], er == 0})
		`CHK(flag_c_o, ec)
	endtask

	task automatic t_shift();
		load(32'h0, 32'h0, 1'b0);
		sh(OP_LOGIC_RIGHT, 32'h0000_0001, 32'h0, 1'b0, 5'h01, 32'h0, 1'b1);
		sh(OP_SHIFT_LEFT, 32'h0, 32'h0, 1'b0, 5'h00, 32'h0, 1'b1);
		sh(OP_ARITH_RIGHT, 32'h8000_0000, 32'h0, 1'b0, 5'h04, 32'hf800_0000,
			1'b0);
		sh(OP_ROTATE_CARRY, 32'h3, 32'h0, 1'b0, 5'h00, 32'h1, 1'b1);
		sh(OP_ROTATE_RIGHT, 32'hf, 32'h104, 1'b1, 5'h00, 32'hf000_0000,
			1'b1);
		$display("shift test done");
	endtask

	task automatic t_count();
		logic [31:0] ops[3] = '{32'h0, 32'h8000_0000, 32'h0001_ffff};
		logic [31:0] exp[3] = '{ALL_ZERO_CNT, 32'h0, 32'hf};
		for (int i = 0; i < 3; i++) begin
			go(OP_LEAD_ZERO_COUNT, 32'hffff_ffff, ops[i], 11'h600);
			`CHK({wr_result_o, result_o}, {1'b1, exp[i]})
			`CHK({flags_wr_o, flag_n_o, flag_z_o, flag_c_o}, 4'b0101)
		end
		$display("count test done");
	endtask

	task automatic t_mac();
		load(32'h5, 32'h0, 1'b0);
		go(OP_MUL_ACC_LONG, 32'hffff_fffe, 32'h3, 11'h400);
		`CHK(wr_accum_o, 1'b1)
		`CHK({accum_high_word_o, accum_low_word_o}, 64'hffff_ffff_ffff_ffff)
		go(OP_MUL_ACC_LONG, 32'h1, 32'h1, 11'h400);
		`CHK({accum_high_word_o, accum_low_word_o}, 64'h0)
		`CHK(flags_wr_o, 1'b0)
		$display("word mac test done");
	endtask

	task automatic t_half();
		for (int i = 0; i < 4; i++) begin
			load(32'h0, 32'h1, 1'b0);
			go(OP_HALF_SELECT_MAC, 32'h0003_fffe, 32'h0005_0007,
				{3'h4, 2'(i), 1'b0, 5'h0});
			`CHK({accum_high_word_o, accum_low_word_o},
				64'h1_0000_0000 + 64'(tab[i]))
		end
		$display("halfword mac test done");
	endtask

	task automatic t_dual();
		load(32'h0, 32'h1, 1'b0);
		go(OP_DUAL_HALF_MAC, 32'h0003_fffe, 32'h0005_0007, 11'h400);
		`CHK({accum_high_word_o, accum_low_word_o}, 64'h1_0000_0001)
		load(32'h0, 32'h1, 1'b0);
		go(OP_DUAL_HALF_MAC, 32'h0003_fffe, 32'h0005_0007, 11'h500);
		`CHK({accum_high_word_o, accum_low_word_o}, 64'h1_0000_000b)
		$display("dual mac test done");
	endtask

	task automatic t_cond();
		go(OP_MUL_ACC_LONG, 32'h7, 32'h7, 11'h000);
		`CHK({wr_accum_o, accum_low_word_o}, {1'b0, 32'hb})
		go(OP_LOGIC_RIGHT, 32'h0, 32'h0, 11'h201);
		`CHK({wr_result_o, flags_wr_o, flag_c_o}, 3'b001)
		$display("condition test done");
	endtask

	// Reset, then the scenarios in turn
	initial begin
		{fail_count, samples_checked, cyc} = '0;
		{rst_i, req_valid_i, ld, ld_c} = 4'b1000;
		{cond_pass_i, flag_upd_i, cross_i, sel_first_top_i} = '0;
		{sel_second_top_i, amt_from_reg_i, amt_imm_i} = '0;
		{first_operand_reg_i, second_operand_reg_i, ld_lo, ld_hi} = '0;
		op_i = OP_SHIFT_LEFT;
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_shift();
		t_count();
		t_mac();
		t_half();
		t_dual();
		t_cond();
		close_out();
	end
endmodule
